// ### hw/scu_defs.svh
`ifndef SCU_DEFS_SVH
`define SCU_DEFS_SVH

// Register indices on the CPU register port.
`define SCU_IDX_CONTROL   3'h0
`define SCU_IDX_STATUS    3'h1
`define SCU_IDX_TX_BUF    3'h2
`define SCU_IDX_RX_BUF    3'h3
`define SCU_IDX_BAUD_CMP  3'h4

// Control register field positions.
`define SCU_CON_MODE_LO   0
`define SCU_CON_MODE_HI   2
`define SCU_CON_PAR_EN    3
`define SCU_CON_PAR_EVEN  4
`define SCU_CON_REN       5
`define SCU_CON_CTS_EN    6
`define SCU_CON_NINTH     7
`define SCU_CON_BREAK     8

// Status register field positions.
`define SCU_STS_NINTH_PAR 0
`define SCU_STS_RX_REQ    1
`define SCU_STS_TX_REQ    2
`define SCU_STS_FRAMING   3
`define SCU_STS_TX_EMPTY  4
`define SCU_STS_OE        5
`define SCU_STS_CTS       6
`define SCU_STS_BRK_SHORT 7
`define SCU_STS_BRK_LONG  8

// Reset values.
`define SCU_CON_RESET     16'h0000
`define SCU_BAUD_RESET    16'h0009

// Timing counts and FIFO depth.
`define SCU_OVERSAMPLE    4'h8
`define SCU_MID_SAMPLE    3'h3
`define SCU_FIFO_DEPTH    8

`endif

// ### hw/scu_pkg.sv
`default_nettype none
package scu_pkg;

  typedef enum logic [2:0] {
    SCU_MODE_SYNC  = 3'b000,
    SCU_MODE_ASY1  = 3'b001,
    SCU_MODE_ASY2  = 3'b010,
    SCU_MODE_ASY3  = 3'b011,
    SCU_MODE_ASY4  = 3'b100,
    SCU_MODE_RSV5  = 3'b101,
    SCU_MODE_RSV6  = 3'b110,
    SCU_MODE_RSV7  = 3'b111
  } scu_mode_t;

  typedef logic [15:0] scu_word_t;

endpackage
`default_nettype wire

// ### hw/scu_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "scu_defs.svh"

// ********************************************************************
// Transmit data FIFO
// ********************************************************************
module scu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SCU_FIFO_DEPTH
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign do_wr       = i_in_valid && o_in_ready;
  assign do_rd       = o_out_valid && i_out_ready;
  assign o_out_data  = mem[rd_ptr];

  always_ff @(posedge i_sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule // scu_fifo

// ********************************************************************
// Serial channel
// ********************************************************************
module scu_channel #(
  parameter int FIFO_DEPTH = `SCU_FIFO_DEPTH
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rstn,
  input  wire logic [2:0]        i_reg_idx,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire scu_pkg::scu_word_t i_reg_wdata,
  output scu_pkg::scu_word_t     o_reg_rdata,
  output logic                   o_tx_wr_ready,
  output logic                   o_txd,
  input  wire logic              i_rxd,
  output logic                   o_rxd_out,
  output logic                   o_rxd_oe,
  input  wire logic              i_cts_n
);
  import scu_pkg::*;

  // ******************************************************************
  // Helpers
  // ******************************************************************
  function automatic logic par_bit(input logic [7:0] d, input logic even);
    par_bit = even ? ^d : ~^d;
  endfunction

  function automatic logic [3:0] data_bits(input scu_mode_t m);
    unique case (m)
      SCU_MODE_SYNC: data_bits = 4'h8;
      SCU_MODE_ASY1: data_bits = 4'h8;
      SCU_MODE_ASY2: data_bits = 4'h9;
      SCU_MODE_ASY3: data_bits = 4'h9;
      SCU_MODE_ASY4: data_bits = 4'h7;
      default:       data_bits = 4'h8;
    endcase
  endfunction

  // ******************************************************************
  // Registers and synchronisers
  // ******************************************************************
  scu_word_t   control;
  scu_word_t   baud_cmp;
  logic [7:0]  rx_holding_buffer;
  logic        rx_unread;
  logic        rx_request_flag, tx_request_flag, framing_flag, tx_empty_flag;
  logic        overrun_flag, rx_ninth_or_parity_flag, short_break_flag, long_break_flag;
  logic        cts_meta, cts_sync, rxd_meta, rxd_sync;

  scu_mode_t   mode_select;
  logic        parity_enable, parity_even_select, rx_enable, clear_to_send_enable;
  logic        tx_ninth_bit, send_break, mode_ok, is_sync;
  logic        sts_access;

  assign mode_select          = scu_mode_t'(control[`SCU_CON_MODE_HI:`SCU_CON_MODE_LO]);
  assign parity_enable        = control[`SCU_CON_PAR_EN];
  assign parity_even_select   = control[`SCU_CON_PAR_EVEN];
  assign rx_enable            = control[`SCU_CON_REN];
  assign clear_to_send_enable = control[`SCU_CON_CTS_EN];
  assign tx_ninth_bit         = control[`SCU_CON_NINTH];
  assign send_break           = control[`SCU_CON_BREAK];
  assign is_sync              = (mode_select == SCU_MODE_SYNC);
  assign mode_ok              = !mode_select[2] || (mode_select == SCU_MODE_ASY4);
  assign sts_access           = (i_reg_wr || i_reg_rd) && (i_reg_idx == `SCU_IDX_STATUS);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      cts_meta <= 1'b1;
      cts_sync <= 1'b1;
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      cts_meta <= i_cts_n;
      cts_sync <= cts_meta;
      rxd_meta <= i_rxd;
      rxd_sync <= rxd_meta;
    end
  end

  // ******************************************************************
  // Baud generator
  // ******************************************************************
  logic [14:0] bcnt;
  logic [14:0] half;
  logic        tick;

  assign tick = (bcnt == baud_cmp[14:0]);
  assign half = 15'((16'(baud_cmp[14:0]) + 16'h0001) >> 1);

  // In sync mode each baud pulse is one whole bit period.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      bcnt <= '0;
    end else begin
      bcnt <= tick ? '0 : bcnt + 15'h0001;
    end
  end

  // ******************************************************************
  // Transmit path: FIFO, holding buffer, shifter
  // ******************************************************************
  logic        fifo_valid;
  logic [7:0]  fifo_data;
  logic        hold_valid;
  logic [7:0]  tx_holding_buffer;
  logic        tx_busy, tx_start, tx_mid, tx_end, cts_ok;
  logic [10:0] tx_sh;
  logic [3:0]  tx_bit, tx_last;
  logic [2:0]  tx_sub;
  logic [10:0] next_frame;
  logic [7:0]  d8;
  logic        rx_busy;

  scu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .i_sys_clk  (i_sys_clk),
    .i_rstn     (i_rstn),
    .i_in_valid (i_reg_wr && (i_reg_idx == `SCU_IDX_TX_BUF)),
    .o_in_ready (o_tx_wr_ready),
    .i_in_data  (i_reg_wdata[7:0]),
    .o_out_valid(fifo_valid),
    .i_out_ready(!hold_valid),
    .o_out_data (fifo_data)
  );

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      hold_valid        <= 1'b0;
      tx_holding_buffer <= 8'h00;
    end else if (!hold_valid && fifo_valid) begin
      hold_valid        <= 1'b1;
      tx_holding_buffer <= fifo_data;
    end else if (tx_start) begin
      hold_valid <= 1'b0;
    end
  end

  // CTS is sampled only while a byte waits, so an early pulse does not arm it.
  assign cts_ok   = !clear_to_send_enable || !cts_sync;
  assign tx_start = tick && !tx_busy && hold_valid && cts_ok && mode_ok
                    && !(is_sync && rx_busy);
  assign tx_last  = is_sync ? 4'h7 : data_bits(mode_select) + 4'h1;
  assign tx_mid   = tx_busy && (tx_bit == tx_last) && (is_sync ? (bcnt == half)
                    : (tick && tx_sub == `SCU_MID_SAMPLE));
  assign tx_end   = tx_busy && tick && (tx_bit == tx_last) && (is_sync || tx_sub == 3'h7);

  always_comb begin
    d8 = tx_holding_buffer;
    next_frame = {3'b111, d8};
    unique case (mode_select)
      SCU_MODE_ASY1: begin
        if (parity_enable) begin
          d8[7] = par_bit({1'b0, d8[6:0]}, parity_even_select);
        end
        next_frame = {2'b11, d8, 1'b0};
      end
      SCU_MODE_ASY2, SCU_MODE_ASY3: begin
        next_frame = {1'b1, parity_enable ? par_bit(d8, parity_even_select) : tx_ninth_bit,
                      d8, 1'b0};
      end
      SCU_MODE_ASY4: next_frame = {3'b111, d8[6:0], 1'b0};
      default:       next_frame = {3'b111, d8};
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      tx_busy <= 1'b0;
      tx_sh   <= '1;
      tx_bit  <= 4'h0;
      tx_sub  <= 3'h0;
    end else if (tx_start) begin
      tx_busy <= 1'b1;
      tx_sh   <= next_frame;
      tx_bit  <= 4'h0;
      tx_sub  <= 3'h0;
    end else if (tx_end) begin
      tx_busy <= 1'b0;
      tx_sh   <= '1;
    end else if (tx_busy && tick) begin
      tx_sub <= tx_sub + 3'h1;
      if (is_sync || tx_sub == 3'h7) begin
        tx_sh  <= {1'b1, tx_sh[10:1]};
        tx_bit <= tx_bit + 4'h1;
      end
    end
  end

  // ******************************************************************
  // Pins
  // ******************************************************************
  logic sync_clk_low;

  // Clock is low for the first half of each bit and rises at mid-bit.
  assign sync_clk_low = is_sync && (tx_busy || rx_busy) && (bcnt < half);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_txd     <= 1'b1;
      o_rxd_out <= 1'b1;
      o_rxd_oe  <= 1'b0;
    end else begin
      o_txd     <= !send_break && !sync_clk_low
                   && (is_sync || !tx_busy || tx_sh[0]);
      o_rxd_out <= tx_sh[0];
      o_rxd_oe  <= is_sync && tx_busy;
    end
  end

  // ******************************************************************
  // Receive shifter
  // ******************************************************************
  logic [8:0] rx_sh;
  logic [3:0] rx_bit;
  logic [2:0] rx_sub;
  logic       rx_fin, rx_stop;
  logic [8:0] rx_data9;
  logic [3:0] nd;

  assign nd       = data_bits(mode_select);
  assign rx_data9 = rx_sh >> (4'h9 - nd);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rx_busy <= 1'b0;
      rx_sh   <= 9'h000;
      rx_bit  <= 4'h0;
      rx_sub  <= 3'h0;
      rx_fin  <= 1'b0;
      rx_stop <= 1'b1;
    end else begin
      rx_fin <= 1'b0;
      if (!rx_enable || !mode_ok) begin
        rx_busy <= 1'b0;
      end else if (is_sync) begin
        if (!rx_busy) begin
          if (tick && !rx_request_flag && !tx_busy && !tx_start) begin
            rx_busy <= 1'b1;
            rx_bit  <= 4'h0;
          end
        end else if (bcnt == half - 15'h0001) begin
          rx_sh  <= {rxd_sync, rx_sh[8:1]};
          rx_bit <= rx_bit + 4'h1;
          if (rx_bit == 4'h7) begin
            rx_busy <= 1'b0;
            rx_fin  <= 1'b1;
            rx_stop <= 1'b1;
          end
        end
      end else if (!rx_busy) begin
        if (tick && !rxd_sync) begin
          rx_busy <= 1'b1;
          rx_bit  <= 4'h0;
          rx_sub  <= 3'h1;
        end
      end else if (tick) begin
        rx_sub <= rx_sub + 3'h1;
        if (rx_sub == `SCU_MID_SAMPLE) begin
          if (rx_bit == 4'h0 && rxd_sync) begin
            rx_busy <= 1'b0;
          end else if (rx_bit == nd + 4'h1) begin
            rx_busy <= 1'b0;
            rx_fin  <= 1'b1;
            rx_stop <= rxd_sync;
          end else begin
            if (rx_bit != 4'h0) begin
              rx_sh <= {rxd_sync, rx_sh[8:1]};
            end
            rx_bit <= rx_bit + 4'h1;
          end
        end
      end
    end
  end

  // ******************************************************************
  // Break detection
  // ******************************************************************
  logic [11:0] brk_cnt;
  logic [11:0] frame_ticks;
  logic        short_brk, long_brk;

  assign frame_ticks = 12'(nd + 4'h2) * 12'(`SCU_OVERSAMPLE);
  assign short_brk   = !is_sync && (brk_cnt > frame_ticks);
  assign long_brk    = !is_sync && (brk_cnt > 12'(frame_ticks * 12'h002)
                       + 12'(12'h003 * 12'(`SCU_OVERSAMPLE)));

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      brk_cnt <= 12'h000;
    end else if (rxd_sync || is_sync) begin
      brk_cnt <= 12'h000;
    end else if (tick && brk_cnt != 12'hFFF) begin
      brk_cnt <= brk_cnt + 12'h001;
    end
  end

  // ******************************************************************
  // Receive buffer and status flags
  // ******************************************************************
  logic rx_accept, rx_perr;

  // Mode 2 drops frames whose ninth bit is low, leaving every flag untouched.
  assign rx_accept = rx_fin && !(mode_select == SCU_MODE_ASY2 && !rx_data9[8]);
  assign rx_perr   = (mode_select == SCU_MODE_ASY1)
                     ? (rx_data9[7] != par_bit({1'b0, rx_data9[6:0]}, parity_even_select))
                     : (rx_data9[8] != par_bit(rx_data9[7:0], parity_even_select));

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rx_holding_buffer <= 8'h00;
      rx_unread         <= 1'b0;
    end else if (rx_accept) begin
      rx_holding_buffer <= rx_data9[7:0];
      rx_unread         <= 1'b1;
    end else if (i_reg_rd && i_reg_idx == `SCU_IDX_RX_BUF) begin
      rx_unread <= 1'b0;
    end
  end

  // A flag event in the same cycle as a status access survives the clear.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rx_request_flag         <= 1'b0;
      tx_request_flag         <= 1'b0;
      framing_flag            <= 1'b0;
      tx_empty_flag           <= 1'b1;
      overrun_flag            <= 1'b0;
      rx_ninth_or_parity_flag <= 1'b0;
      short_break_flag        <= 1'b0;
      long_break_flag         <= 1'b0;
    end else begin
      rx_request_flag  <= (rx_request_flag && !sts_access) || rx_accept;
      tx_request_flag  <= (tx_request_flag && !sts_access) || tx_mid;
      framing_flag     <= (framing_flag && !sts_access) || (rx_accept && !rx_stop);
      overrun_flag     <= (overrun_flag && !sts_access) || (rx_accept && rx_unread);
      tx_empty_flag    <= (tx_empty_flag && !sts_access)
                          || (!hold_valid && !fifo_valid && !tx_busy);
      short_break_flag <= (short_break_flag && !sts_access) || short_brk;
      long_break_flag  <= (long_break_flag && !sts_access) || long_brk;
      if (rx_accept && !is_sync && mode_select != SCU_MODE_ASY4
          && (parity_enable || mode_select != SCU_MODE_ASY1)) begin
        rx_ninth_or_parity_flag <= (parity_enable ? rx_perr : rx_data9[8])
                                   || (parity_enable && rx_ninth_or_parity_flag
                                       && !sts_access);
      end else if (sts_access) begin
        rx_ninth_or_parity_flag <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // Control, baud compare and read data
  // ******************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      control  <= `SCU_CON_RESET;
      baud_cmp <= `SCU_BAUD_RESET;
    end else begin
      if (i_reg_wr && i_reg_idx == `SCU_IDX_CONTROL) begin
        control <= i_reg_wdata;
      end else if (tx_end) begin
        control[`SCU_CON_NINTH] <= 1'b0;
      end
      if (i_reg_wr && i_reg_idx == `SCU_IDX_BAUD_CMP) begin
        baud_cmp <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      o_reg_rdata <= 16'h0000;
      unique case (i_reg_idx)
        `SCU_IDX_CONTROL:  o_reg_rdata <= {7'h00, control[8:0]};
        `SCU_IDX_STATUS: begin
          o_reg_rdata[`SCU_STS_NINTH_PAR] <= rx_ninth_or_parity_flag;
          o_reg_rdata[`SCU_STS_RX_REQ]    <= rx_request_flag;
          o_reg_rdata[`SCU_STS_TX_REQ]    <= tx_request_flag;
          o_reg_rdata[`SCU_STS_FRAMING]   <= framing_flag;
          o_reg_rdata[`SCU_STS_TX_EMPTY]  <= tx_empty_flag;
          o_reg_rdata[`SCU_STS_OE]        <= overrun_flag;
          o_reg_rdata[`SCU_STS_CTS]       <= !cts_sync;
          o_reg_rdata[`SCU_STS_BRK_SHORT] <= short_break_flag;
          o_reg_rdata[`SCU_STS_BRK_LONG]  <= long_break_flag;
        end
        `SCU_IDX_RX_BUF:   o_reg_rdata <= {8'h00, rx_holding_buffer};
        `SCU_IDX_BAUD_CMP: o_reg_rdata <= baud_cmp;
        default:           o_reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule // scu_channel
`default_nettype wire

// ### testbench/scu_channel_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ********************
// Port rule checker
// ********************
module scu_channel_checker #(parameter int FIFO_DEPTH = 8) (
  input wire logic               i_sys_clk,
  input wire logic               i_rstn,
  input wire logic [2:0]         i_reg_idx,
  input wire logic               i_reg_wr,
  input wire logic               i_reg_rd,
  input wire scu_pkg::scu_word_t i_reg_wdata,
  input wire scu_pkg::scu_word_t o_reg_rdata,
  input wire logic               o_txd,
  input wire logic               o_rxd_out,
  input wire logic               o_rxd_oe,
  input wire logic               i_cts_n
);
  import scu_pkg::*;
  logic [14:0] cmp_q;
  logic        cen_q, brk_q, txd_d, oe_d, rise;
  logic [3:0]  rise_cnt;
  logic [15:0] per_cnt, low_cnt;
  assign rise = o_txd && !txd_d;
  // Control and baud fields are mirrored so clock periods can be predicted.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      cmp_q <= 15'h0009;
      cen_q <= 1'b0;
      brk_q <= 1'b0;
    end else if (i_reg_wr && i_reg_idx == 3'h0) begin
      cen_q <= i_reg_wdata[6];
      brk_q <= i_reg_wdata[8];
    end else if (i_reg_wr && i_reg_idx == 3'h4) begin
      cmp_q <= i_reg_wdata[14:0];
    end
  end
  always_ff @(posedge i_sys_clk) begin
    txd_d    <= i_rstn ? o_txd : 1'b1;
    oe_d     <= i_rstn && o_rxd_oe;
    per_cnt  <= (rise || !i_rstn) ? 16'h0001 : per_cnt + 16'h0001;
    low_cnt  <= (o_txd || !i_rstn) ? 16'h0000 : low_cnt + 16'h0001;
    rise_cnt <= (!i_rstn || (o_rxd_oe && !oe_d)) ? 4'h0 : rise_cnt + {3'h0, rise && o_rxd_oe};
  end
  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  frame_eight_a: assert property ($fell(o_rxd_oe) |-> rise_cnt == 4'h8)
    else $error("transmit frame did not carry eight clock rises");
  data_steady_a: assert property (o_rxd_oe && $rose(o_txd) |-> $stable(o_rxd_out))
    else $error("data pin moved at the shift clock rise");
  bit_period_a: assert property (o_rxd_oe && rise && rise_cnt != 4'h0 |-> per_cnt == {1'b0, cmp_q} + 16'h0001)
    else $error("shift clock period differs from one baud pulse");
  low_half_a: assert property (o_rxd_oe && rise |-> low_cnt == ({1'b0, cmp_q} + 16'h0001) >> 1)
    else $error("shift clock low time differs from half a bit");
  break_low_a: assert property (brk_q [*3] |-> !o_txd)
    else $error("transmit pin not low during break");
  cts_status_a: assert property ($stable(i_cts_n) [*4] ##0 (i_reg_rd && i_reg_idx == 3'h1) |=> o_reg_rdata[6] == !$past(i_cts_n))
    else $error("status clear-to-send bit is not the inverted pin");
  cts_hold_a: assert property ((cen_q && i_cts_n) [*5] |-> !$rose(o_rxd_oe))
    else $error("frame started while clear-to-send was off");
  rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");
endmodule // scu_channel_checker
bind scu_channel scu_channel_checker #(.FIFO_DEPTH(FIFO_DEPTH)) scu_channel_checker_i (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_reg_idx(i_reg_idx), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_txd(o_txd),
  .o_rxd_out(o_rxd_out), .o_rxd_oe(o_rxd_oe), .i_cts_n(i_cts_n));
`default_nettype wire

// ### testbench/scu_shift_peer.sv
`timescale 1ns/100ps
`default_nettype none
// ********************
// Shift register peer
// ********************
module scu_shift_peer (
  input  wire logic       i_sck,
  input  wire logic       i_oe,
  input  wire logic       i_sdi,
  input  wire logic       i_load,
  input  wire logic [7:0] i_par,
  output logic            o_sdo,
  output logic [7:0]      o_cap
);
  logic [7:0] sr;
  assign o_sdo = sr[0];
  // Spent bits are refilled inverted so a stale level never looks valid.
  always @(posedge i_sck or posedge i_load) begin
    if (i_load) begin
      sr <= i_par;
    end else if (!i_oe) begin
      sr <= {~sr[0], sr[7:1]};
    end
  end
  always @(posedge i_sck) begin
    if (i_oe) begin
      o_cap <= {i_sdi, o_cap[7:1]};
    end
  end
endmodule // scu_shift_peer
`default_nettype wire

// ### testbench/scu_channel_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ********************
// Channel testbench
// ********************
module scu_channel_tb_top;
  import scu_pkg::*;
  logic       sys_clk, rstn, reg_wr, reg_rd, cts_n, tx_ready, txd, rxd_out, rxd_oe, sdo, load, rxd_wire;
  logic [2:0] reg_idx;
  logic [7:0] par, cap;
  scu_word_t  wdata, rdata;
  int         mismatches, cmp_count, n, r;
  assign rxd_wire = rxd_oe ? rxd_out : sdo;
  scu_channel #(.FIFO_DEPTH(8)) scu_channel_i (
    .i_sys_clk(sys_clk), .i_rstn(rstn), .i_reg_idx(reg_idx), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_tx_wr_ready(tx_ready), .o_txd(txd),
    .i_rxd(rxd_wire), .o_rxd_out(rxd_out), .o_rxd_oe(rxd_oe), .i_cts_n(cts_n));
  scu_shift_peer scu_shift_peer_i (.i_sck(txd), .i_oe(rxd_oe), .i_sdi(rxd_wire), .i_load(load),
    .i_par(par), .o_sdo(sdo), .o_cap(cap));
  task automatic chk(input string what, input scu_word_t got, input scu_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] idx, input scu_word_t d);
    @(negedge sys_clk);
    reg_idx = idx;
    wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] idx, input scu_word_t exp, input string what);
    @(negedge sys_clk);
    reg_idx = idx;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk(what, rdata, exp);
  endtask
  task automatic wait_oe(input logic lvl);
    int k;
    k = 0;
    while (rxd_oe !== lvl && k < 2000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 2000) begin
      chk("data pin enable wait", {15'h0, rxd_oe}, {15'h0, lvl});
      tally_and_finish();
    end
  endtask
  task automatic rises(input int cyc, output int cnt);
    logic p;
    cnt = 0;
    p = txd;
    repeat (cyc) begin
      @(negedge sys_clk);
      if (txd && !p) cnt++;
      p = txd;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {rstn, reg_wr, reg_rd, load, reg_idx, wdata, cts_n, par} = {7'h0, 16'h0000, 1'b1, 8'h96};
    mismatches = 0;
    cmp_count = 0;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    load = 1'b1;
    rd(3'h0, 16'h0000, "control reset");
    rd(3'h1, 16'h0010, "status reset");
    rd(3'h4, 16'h0009, "baud reset");
    rd(3'h5, 16'h0000, "unused index");
    load = 1'b0;
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      wr(3'h0, {13'h0, 3'(m)});
      rd(3'h0, {13'h0, 3'(m)}, "mode field");
    end
    wr(3'h0, 16'hFE58);
    rd(3'h0, 16'h0058, "control fields");
    rd(3'h0, 16'h0058, "control reread");
    $display("test control done");
    wr(3'h0, 16'h0100);
    repeat (4) @(negedge sys_clk);
    chk("break pin", {15'h0, txd}, 16'h0000);
    wr(3'h0, 16'h0000);
    repeat (4) @(negedge sys_clk);
    chk("idle clock pin", {15'h0, txd}, 16'h0001);
    chk("idle data enable", {15'h0, rxd_oe}, 16'h0000);
    $display("test break done");
    wr(3'h4, 16'h0003);
    wr(3'h0, 16'h0040);
    n = 0;
    while (tx_ready === 1'b1 && n < 16) begin
      n++;
      wr(3'h2, {8'h00, 8'(n * 17)});
    end
    chk("buffer fill", {15'h0, n >= 8}, 16'h0001);
    repeat (40) @(negedge sys_clk);
    chk("held frame", {15'h0, rxd_oe}, 16'h0000);
    // The empty flag latched before the fill and only a status access drops it.
    rd(3'h1, 16'h0010, "status while held");
    cts_n = 1'b0;
    for (int k = 1; k <= n; k++) begin
      wait_oe(1'b1);
      wait_oe(1'b0);
      chk("shifted byte", {8'h00, cap}, {8'h00, 8'(k * 17)});
    end
    repeat (8) @(negedge sys_clk);
    rd(3'h1, 16'h0054, "status after frames");
    rd(3'h1, 16'h0050, "status cleared");
    wr(3'h0, 16'h0080);
    wr(3'h2, 16'h005A);
    wait_oe(1'b1);
    wait_oe(1'b0);
    chk("ninth bit frame", {8'h00, cap}, 16'h005A);
    rd(3'h0, 16'h0000, "ninth bit cleared");
    rd(3'h1, 16'h0054, "status after ninth");
    $display("test transmit done");
    // The break test gave the peer one clock rise, so its byte is reloaded first.
    load = 1'b1;
    @(negedge sys_clk);
    load = 1'b0;
    wr(3'h0, 16'h0020);
    rises(20, r);
    chk("reception started", {15'h0, r > 0}, 16'h0001);
    repeat (60) @(negedge sys_clk);
    rises(20, r);
    chk("no second reception", 16'(r), 16'h0000);
    wr(3'h0, 16'h0000);
    rd(3'h1, 16'h0052, "status after reception");
    rd(3'h3, 16'h0096, "received byte");
    $display("test receive done");
    tally_and_finish();
  end
endmodule // scu_channel_tb_top
`default_nettype wire
